// File: hw/interrupt_reset_vector_select.sv
`timescale 1ns/1ps
module interrupt_reset_vector_select
  import vector_select_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone classic slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // Reset causes
  input  wire logic                por_req_i,
  input  wire logic                ext_reset_req_i,
  input  wire logic                low_volt_req_i,
  input  wire logic                clock_fail_req_i,
  input  wire logic                watchdog_timeout_i,
  // Interrupt sources and core masks
  input  wire logic [NUM_MASK-1:0] periph_req_i,
  input  wire logic [3:0]          serial_flags_i,
  input  wire logic                nonmaskable_ext_request_i,
  input  wire logic                i_mask_i,
  input  wire logic                x_mask_i,
  // Core side
  output logic [15:0]              vector_o,
  output logic [1:0]               reset_priority_o,
  output logic                     reset_req_o,
  output logic                     nonmaskable_ext_request_req_o,
  output logic                     irq_req_o,
  output logic                     irq_line_o
);

  // ****************************************
  // Limitations
  // ****************************************
  // No memory array lives here, so a reset of this block never touches
  // the RAM contents; they keep whatever was there before.
  // Trap and software-interrupt vectors are raised inside the core and
  // never pass through this selection.
  // Reserved table slots have no request bit, so they can never win.
  // Reset causes are sampled as levels; a pulse that falls between two
  // clock edges is lost, so the cause logic must stretch its pulses.
  // The elevation code only helps a source while it is pending; a code
  // that matches no table entry leaves the default order in place.
  // Vector and request kinds lag their causes by one edge.
  // Only the low byte lane carries writable register bits; the current word spans three lanes.

  // ****************************************
  // Registers
  // ****************************************
  // Register map, byte addresses on the bus, all but current in the low lane:
  //   elevation code     one byte, start-up value picks the top slot
  //   watchdog control   clock monitor enables and rate select
  //   timer enables      one bit per timer channel, lowest channel first
  //   pulse accumulator  overflow enable, then edge enable
  //   serial enables     one bit per serial flag, same order as the flags
  //   status             sticky events, read only
  //   clear              write one to clear a status bit, reads zero
  //   enable             interrupt line enables, same layout as status
  //   current            last vector, reset and external request kinds, reset priority
  // Unmapped addresses read zero and ignore writes but still answer,
  // so a stray access never hangs the bus.
  logic [7:0]          elev_reg;
  logic [7:0]          watchdog_control_reg;
  logic [5:0]          timer_en_reg;
  logic [1:0]          pulse_accum_control_reg;
  logic [3:0]          serial_comm_control_two_reg;
  // Sticky event status and its enables
  logic [NUM_EVT-1:0]  stat_reg;
  logic [NUM_EVT-1:0]  stat_next;
  logic [NUM_EVT-1:0]  ien_reg;
  // Bus answer and read data
  logic                ack_reg;
  logic [31:0]         dat_reg;
  // Registered copies of what the core sees
  logic [15:0]         vector_reg;
  logic [15:0]         vector_next;
  logic [1:0]          rprio_reg;
  logic [1:0]          rprio_next;
  logic                reset_req_reg;
  logic                nonmaskable_ext_request_req_reg;
  logic                irq_req_reg;
  logic                irq_line_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  // Register slot match, shared by every write decode
  function automatic logic reg_sel(input logic [7:0] adr,
                                   input logic [7:0] slot);
    return adr == slot;
  endfunction

  // The answer comes one edge after a request is seen; the ack flop
  // blocks a second decode of a request that is still held, so a held
  // write lands once and a held read is not taken twice.
  // Only the lowest lane carries writable register bits; upper write lanes are ignored.
  wire        bus_req  = cyc_i && stb_i && !ack_reg;
  wire        wr_en    = bus_req && we_i && sel_i[0];
  wire        wr_hi    = bus_req && we_i && sel_i[1];
  wire        wr_elev  = wr_en && reg_sel(adr_i, ADDR_ELEV);
  wire        wr_wdctl = wr_en && reg_sel(adr_i, ADDR_WDCTL);
  wire        wr_tmren = wr_en && reg_sel(adr_i, ADDR_TMREN);
  wire        wr_pulse_accum_control = wr_en && reg_sel(adr_i, ADDR_PULSE_ACCUM_CONTROL);
  wire        wr_sci   = wr_en && reg_sel(adr_i, ADDR_SCICTL);
  wire        wr_clr   = wr_en && reg_sel(adr_i, ADDR_CLR);
  wire        wr_ien   = wr_en && reg_sel(adr_i, ADDR_IEN);
  wire [NUM_EVT-1:0] clr_mask = wr_clr ? dat_i[NUM_EVT-1:0] : '0;

  // ****************************************
  // Reset selection
  // ****************************************
  // Order of precedence, first match wins:
  //   power-on, pin and low-voltage resets share the top vector pair
  //   clock monitor reset, when either monitor enable bit is set
  //   watchdog reset, when the rate select is not zero
  //   non-maskable external request, unless the core masks it
  //   elevated maskable request, then the table order
  // A cause that is gated off is dropped here, so it neither moves the
  // vector nor sets a status bit.
  // Both bits enable the monitor; a zero rate turns the watchdog off
  wire clkmon_en = watchdog_control_reg[WD_CME_BIT] ||
                   watchdog_control_reg[WD_FORCED_CLOCK_MONITOR_ENABLE_BIT];
  wire wdog_en   = |watchdog_control_reg[WD_RATE_LSB +: WD_RATE_W];
  wire top_rst   = por_req_i || ext_reset_req_i || low_volt_req_i;
  wire clk_rst   = clock_fail_req_i && clkmon_en;
  wire wdog_rst  = watchdog_timeout_i && wdog_en;
  wire any_rst   = top_rst || clk_rst || wdog_rst;

  // ****************************************
  // Maskable request gating
  // ****************************************
  logic [NUM_MASK-1:0] pend;
  logic                pick_found;
  logic [7:0]          pick_code;

  // Sources without a local enable here are taken as already gated by
  // their own block. The serial slot ignores its table bit and uses the
  // four flags instead, so a stale table bit cannot raise it.
  // Local enables only for the sources whose control bits live here
  always_comb begin
    pend = periph_req_i;
    pend[IDX_TMR2 +: 6] = periph_req_i[IDX_TMR2 +: 6] & timer_en_reg;
    pend[IDX_PAOV] = periph_req_i[IDX_PAOV] && pulse_accum_control_reg[0];
    pend[IDX_PAED] = periph_req_i[IDX_PAED] && pulse_accum_control_reg[1];
    pend[IDX_SCI]  = |(serial_flags_i & serial_comm_control_two_reg);
  end

  vector_priority_pick u_pick (
    .pend_i      (pend),
    .elev_code_i (elev_reg),
    .found_o     (pick_found),
    .code_o      (pick_code)
  );

  // Core mask flags gate at request level; the status bit of the
  // non-maskable request records every unmasked request, even one that a reset outranks
  wire irq_ok  = pick_found && !i_mask_i;
  wire nonmaskable_ext_request_ok = nonmaskable_ext_request_i && !x_mask_i;

  // Resets outrank the external request, which outranks maskables
  always_comb begin
    vector_next = 16'h0000;
    rprio_next  = 2'h0;
    if (top_rst) begin
      vector_next = VEC_RESET;
      rprio_next  = RPRIO_TOP;
    end else if (clk_rst) begin
      vector_next = VEC_CLKMON;
      rprio_next  = RPRIO_CLK;
    end else if (wdog_rst) begin
      vector_next = VEC_WATCHDOG;
      rprio_next  = RPRIO_WDOG;
    end else if (nonmaskable_ext_request_ok) begin
      vector_next = VEC_NONMASKABLE_EXT_REQUEST;
    end else if (irq_ok) begin
      vector_next = {VEC_HI, pick_code};
    end
  end

  // ****************************************
  // Event status
  // ****************************************
  // Status bits, lowest first: power-on, pin, low voltage, clock monitor,
  // watchdog, non-maskable request. A bit is set on every cycle that its
  // cause is present, so a clear written while the cause still stands
  // has no effect; software must remove the cause first.
  // Gated-off resets leave no trace here.
  wire [NUM_EVT-1:0] evt = {nonmaskable_ext_request_ok, wdog_rst, clk_rst, low_volt_req_i,
                            ext_reset_req_i, por_req_i};
  // New events win over a clear in the same cycle
  assign stat_next = (stat_reg & ~clr_mask) | evt;

  // ****************************************
  // Read mux
  // ****************************************
  // Write-only clear register falls to the default and reads zero.
  // The current word lets software see what the core was last offered.
  logic [31:0] rd_data;
  always_comb begin
    unique case (adr_i)
      ADDR_ELEV:   rd_data = {24'h000000, elev_reg};
      ADDR_WDCTL:  rd_data = {24'h000000, watchdog_control_reg};
      ADDR_TMREN:  rd_data = {26'h0000000, timer_en_reg};
      ADDR_PULSE_ACCUM_CONTROL:  rd_data = {30'h00000000, pulse_accum_control_reg};
      ADDR_SCICTL: rd_data = {28'h0000000, serial_comm_control_two_reg};
      ADDR_STAT:   rd_data = {26'h0000000, stat_reg};
      ADDR_IEN:    rd_data = {26'h0000000, ien_reg};
      ADDR_CUR:    rd_data = {12'h000, rprio_reg, reset_req_reg,
                              nonmaskable_ext_request_req_reg, vector_reg};
      default:     rd_data = 32'h00000000;
    endcase
  end

  // ****************************************
  // Sequential logic
  // ****************************************
  // Read data is zero outside the answer cycle, so a master that
  // samples late sees zero rather than a stale word.
  // Bus answer one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= (bus_req && !we_i) ? rd_data : 32'h00000000;
    end
  end

  // Control registers; the elevation code is one byte, low lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      elev_reg                    <= ELEV_RST;
      watchdog_control_reg        <= 8'h00;
      timer_en_reg                <= 6'h00;
      pulse_accum_control_reg     <= 2'h0;
      serial_comm_control_two_reg <= 4'h0;
      ien_reg                     <= '0;
    end else begin
      if (wr_elev) begin
        elev_reg <= dat_i[7:0];
      end
      if (wr_wdctl) begin
        watchdog_control_reg <= dat_i[7:0];
      end
      if (wr_tmren) begin
        timer_en_reg <= dat_i[5:0];
      end
      if (wr_pulse_accum_control) begin
        pulse_accum_control_reg <= dat_i[1:0];
      end
      if (wr_sci) begin
        serial_comm_control_two_reg <= dat_i[3:0];
      end
      if (wr_ien) begin
        ien_reg <= dat_i[NUM_EVT-1:0];
      end
    end
  end

  // All core outputs are registered, so the core sees a clean vector one
  // edge after the causes change; the request kinds never overlap.
  // The interrupt line uses the next status value so a new event shows
  // on the line at the same edge that sets its status bit.
  // Core outputs; no memory array here, so nothing is wiped on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg      <= '0;
      vector_reg    <= 16'h0000;
      rprio_reg     <= 2'h0;
      reset_req_reg <= 1'b0;
      nonmaskable_ext_request_req_reg  <= 1'b0;
      irq_req_reg   <= 1'b0;
      irq_line_reg  <= 1'b0;
    end else begin
      stat_reg      <= stat_next;
      vector_reg    <= vector_next;
      rprio_reg     <= rprio_next;
      reset_req_reg <= any_rst;
      nonmaskable_ext_request_req_reg  <= !any_rst && nonmaskable_ext_request_ok;
      irq_req_reg   <= !any_rst && !nonmaskable_ext_request_ok && irq_ok;
      irq_line_reg  <= |(stat_next & ien_reg);
    end
  end

  // Unused upper lane of a write is ignored
  wire unused_hi = wr_hi;

  // Every output comes straight from a flop
  assign dat_o            = dat_reg;
  assign ack_o            = ack_reg;
  assign vector_o         = vector_reg;
  assign reset_priority_o = rprio_reg;
  assign reset_req_o      = reset_req_reg;
  assign nonmaskable_ext_request_req_o       = nonmaskable_ext_request_req_reg;
  assign irq_req_o        = irq_req_reg;
  assign irq_line_o       = irq_line_reg;

endmodule

// File: hw/vector_select_pkg.sv
// What this block does
// - Pending requests are ranked by vector address, higher address first.
// - Resets use the same vector path and outrank every interrupt.
// - Power-on, pin and low-voltage reset share vector 0xFFFE/0xFFFF.
// - Those three resets carry reset priority 1, the highest.
// - Clock monitor reset has priority 2, vector 0xFFFC, only if enabled.
// - Watchdog reset has priority 3, vector 0xFFFA, enabled by rate select.
// - Writing a source's vector low byte as code elevates it to the top.
// - Timer channels 2 to 7 each request alone, gated by their own enable.
// - Pulse accumulator overflow requests, gated by its overflow enable.
// - Pulse accumulator edge requests, gated by its edge enable.
// - The serial unit ORs its four enabled flags onto one vector.
// - Only the block reset rst_i forces every register to its start-up value; reset causes do not.
// - Reset never clears or initialises the RAM array.
package vector_select_pkg;

  // ****************************************
  // Vector space
  // ****************************************
  localparam int          NUM_MASK     = 24;
  localparam logic [7:0]  VEC_HI       = 8'hFF;
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON   = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;
  localparam logic [15:0] VEC_NONMASKABLE_EXT_REQUEST     = 16'hFFF4;
  localparam logic [1:0]  RPRIO_TOP    = 2'h1;
  localparam logic [1:0]  RPRIO_CLK    = 2'h2;
  localparam logic [1:0]  RPRIO_WDOG   = 2'h3;

  // Low bytes of implemented maskable vectors, highest first
  localparam logic [7:0] MASK_CODE [NUM_MASK] = '{
    8'hF2, 8'hF0, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0,
    8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD2, 8'hCE, 8'hC6,
    8'hC4, 8'hB8, 8'hB6, 8'hB4, 8'hB2, 8'hB0, 8'h8E, 8'h8A};
  localparam int IDX_TMR2 = 2;
  localparam int IDX_PAOV = 9;
  localparam int IDX_PAED = 10;
  localparam int IDX_SCI  = 12;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_ELEV   = 8'h00;
  localparam logic [7:0] ADDR_WDCTL  = 8'h04;
  localparam logic [7:0] ADDR_TMREN  = 8'h08;
  localparam logic [7:0] ADDR_PULSE_ACCUM_CONTROL  = 8'h0C;
  localparam logic [7:0] ADDR_SCICTL = 8'h10;
  localparam logic [7:0] ADDR_STAT   = 8'h14;
  localparam logic [7:0] ADDR_CLR    = 8'h18;
  localparam logic [7:0] ADDR_IEN    = 8'h1C;
  localparam logic [7:0] ADDR_CUR    = 8'h20;

  localparam logic [7:0] ELEV_RST    = 8'hF2;
  localparam int         WD_RATE_LSB = 0;
  localparam int         WD_RATE_W   = 3;
  localparam int         WD_FORCED_CLOCK_MONITOR_ENABLE_BIT = 6;
  localparam int         WD_CME_BIT  = 7;
  localparam int         NUM_EVT     = 6;
  // Event bits: 0 por, 1 pin, 2 low volt, 3 clk mon, 4 watchdog, 5 nonmaskable_ext_request

endpackage

// File: hw/vector_priority_pick.sv
`timescale 1ns/1ps
module vector_priority_pick
  import vector_select_pkg::*;
(
  input  wire logic [NUM_MASK-1:0] pend_i,
  input  wire logic [7:0]          elev_code_i,
  output logic                     found_o,
  output logic [7:0]               code_o
);

  // Table lookup of one slot
  function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // Default order by descending index so the top slot wins; the elevated
  // one overrides; only table codes can come out, never reserved slots
  always_comb begin
    found_o = 1'b0;
    code_o  = 8'h00;
    for (int i = NUM_MASK - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        found_o = 1'b1;
        code_o  = MASK_CODE[i];
      end
    end
    for (int i = 0; i < NUM_MASK; i++) begin
      if (pend_i[i] && slot_hit(MASK_CODE[i], elev_code_i)) begin
        code_o = MASK_CODE[i];
      end
    end
  end

endmodule

// File: tb/irvs_sva.sv
`timescale 1ns/1ps
module irvs_sva
  import vector_select_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        por_req_i,
  input wire logic        ext_reset_req_i,
  input wire logic        low_volt_req_i,
  input wire logic        i_mask_i,
  input wire logic        x_mask_i,
  input wire logic [15:0] vector_o,
  input wire logic [1:0]  reset_priority_o,
  input wire logic        reset_req_o,
  input wire logic        nonmaskable_ext_request_req_o,
  input wire logic        irq_req_o
);
  // ****
  // Vector and handshake checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire top_rst = por_req_i | ext_reset_req_i | low_volt_req_i;

  a_top_reset_vec: assert property (
    top_rst |=> vector_o == VEC_RESET && reset_priority_o == RPRIO_TOP)
    else $error("top reset vector wrong");
  a_reset_wins: assert property (
    top_rst |=> reset_req_o && !irq_req_o && !nonmaskable_ext_request_req_o)
    else $error("interrupt beat a reset");
  a_req_exclusive: assert property (
    $onehot0({reset_req_o, nonmaskable_ext_request_req_o, irq_req_o}))
    else $error("two request kinds at once");
  a_clk_mon_pair: assert property (
    reset_priority_o == RPRIO_CLK |-> vector_o == VEC_CLKMON)
    else $error("clock monitor vector wrong");
  a_wdog_pair: assert property (
    reset_priority_o == RPRIO_WDOG |-> vector_o == VEC_WATCHDOG)
    else $error("watchdog vector wrong");
  a_i_mask_gate: assert property (i_mask_i |=> !irq_req_o)
    else $error("maskable request while masked");
  a_x_mask_gate: assert property (x_mask_i |=> !nonmaskable_ext_request_req_o)
    else $error("external request while masked");
  a_no_reserved: assert property (
    irq_req_o |-> vector_o[15:8] == VEC_HI && vector_o[7:0] inside {MASK_CODE})
    else $error("reserved vector produced");
  a_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");

  cover property (reset_priority_o == RPRIO_CLK);
  cover property (nonmaskable_ext_request_req_o);
  cover property (irq_req_o && vector_o == 16'hFF8A);
endmodule

bind interrupt_reset_vector_select irvs_sva u_sva (
  .clk_i            (clk_i),
  .rst_i            (rst_i),
  .cyc_i            (cyc_i),
  .stb_i            (stb_i),
  .ack_o            (ack_o),
  .por_req_i        (por_req_i),
  .ext_reset_req_i  (ext_reset_req_i),
  .low_volt_req_i   (low_volt_req_i),
  .i_mask_i         (i_mask_i),
  .x_mask_i         (x_mask_i),
  .vector_o         (vector_o),
  .reset_priority_o (reset_priority_o),
  .reset_req_o      (reset_req_o),
  .nonmaskable_ext_request_req_o       (nonmaskable_ext_request_req_o),
  .irq_req_o        (irq_req_o)
);

// File: tb/core_fetch_model.sv
`timescale 1ns/1ps
module core_fetch_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [15:0] vector_i,
  output logic [15:0]      fetched_o = '0
);
  // Core takes the offered vector whenever any request is raised
  always_ff @(posedge clk_i) begin
    if (req_i) begin
      fetched_o <= vector_i;
    end
  end
endmodule

// File: tb/interrupt_reset_vector_select_tb.sv
`timescale 1ns/1ps
module interrupt_reset_vector_select_tb;
  import vector_select_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = 4'hF, serial_flags_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic por_req_i = 0, ext_reset_req_i = 0, low_volt_req_i = 0;
  logic clock_fail_req_i = 0, watchdog_timeout_i = 0;
  logic nonmaskable_ext_request_i = 0, i_mask_i = 0, x_mask_i = 0;
  logic [NUM_MASK-1:0] periph_req_i = '0;
  logic [15:0] vector_o, fetched;
  logic [1:0] reset_priority_o;
  logic reset_req_o, nonmaskable_ext_request_req_o, irq_req_o, irq_line_o;
  int bad_count = 0, comparisons = 0;

  interrupt_reset_vector_select DUT (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .cyc_i                     (cyc_i),
    .stb_i                     (stb_i),
    .we_i                      (we_i),
    .adr_i                     (adr_i),
    .sel_i                     (sel_i),
    .dat_i                     (dat_i),
    .dat_o                     (dat_o),
    .ack_o                     (ack_o),
    .por_req_i                 (por_req_i),
    .ext_reset_req_i           (ext_reset_req_i),
    .low_volt_req_i            (low_volt_req_i),
    .clock_fail_req_i          (clock_fail_req_i),
    .watchdog_timeout_i        (watchdog_timeout_i),
    .periph_req_i              (periph_req_i),
    .serial_flags_i            (serial_flags_i),
    .nonmaskable_ext_request_i (nonmaskable_ext_request_i),
    .i_mask_i                  (i_mask_i),
    .x_mask_i                  (x_mask_i),
    .vector_o                  (vector_o),
    .reset_priority_o          (reset_priority_o),
    .reset_req_o               (reset_req_o),
    .nonmaskable_ext_request_req_o                (nonmaskable_ext_request_req_o),
    .irq_req_o                 (irq_req_o),
    .irq_line_o                (irq_line_o)
  );
  core_fetch_model u_core (.clk_i(clk_i),
    .req_i(reset_req_o | nonmaskable_ext_request_req_o | irq_req_o),
    .vector_i(vector_o), .fetched_o(fetched));

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle, held until ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  // Outputs follow inputs one edge later
  task automatic expv(input logic [15:0] v, input logic [1:0] p);
    logic [2:0] kind;
    @(posedge clk_i);
    #1;
    check(vector_o, v);
    check(reset_priority_o, p);
    // Request kind follows from the expected vector and priority
    kind = (p != 2'h0) ? 3'b100 : (v == VEC_NONMASKABLE_EXT_REQUEST) ? 3'b010 : 3'b000;
    if (kind == 3'b000 && v != 16'h0000) kind = 3'b001;
    check({reset_req_o, nonmaskable_ext_request_req_o, irq_req_o}, kind);
    @(posedge clk_i);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic regs_after_reset;
    wb(0, ADDR_ELEV, 0);
    check(rd, {24'h0, ELEV_RST});
    wb(0, ADDR_WDCTL, 0);
    check(rd, 0);
    wb(0, 8'h40, 0);
    check(rd, 0);
  endtask
  task automatic reset_causes;
    clock_fail_req_i <= 1;
    periph_req_i <= 24'h000001;
    for (int k = 0; k < 3; k++) begin
      {por_req_i, ext_reset_req_i, low_volt_req_i} <= 3'b1 << k;
      expv(VEC_RESET, RPRIO_TOP);
    end
    #1;
    check(fetched, VEC_RESET);
    @(posedge clk_i);
    {por_req_i, ext_reset_req_i, low_volt_req_i} <= 3'b0;
    expv(16'hFFF2, 2'h0);
    wb(1, ADDR_WDCTL, 32'h80);
    expv(VEC_CLKMON, RPRIO_CLK);
    clock_fail_req_i <= 0;
    watchdog_timeout_i <= 1;
    expv(16'hFFF2, 2'h0);
    wb(1, ADDR_WDCTL, 32'h41);
    expv(VEC_WATCHDOG, RPRIO_WDOG);
    wb(0, ADDR_CUR, 0);
    check(rd, 32'h000EFFFA);
    clock_fail_req_i <= 1;
    expv(VEC_CLKMON, RPRIO_CLK);
    clock_fail_req_i <= 0;
    watchdog_timeout_i <= 0;
  endtask
  task automatic timers;
    wb(1, ADDR_TMREN, 32'h3F);
    for (int c = 0; c < 6; c++) begin
      periph_req_i <= 24'h1 << (IDX_TMR2 + c);
      expv(16'hFFEA - 16'(2 * c), 2'h0);
    end
    periph_req_i <= 24'h000084;
    expv(16'hFFEA, 2'h0);
    wb(1, ADDR_TMREN, 32'h3E);
    expv(16'hFFE0, 2'h0);
  endtask
  task automatic pulse_and_serial;
    periph_req_i <= 24'h001600;
    wb(1, ADDR_PULSE_ACCUM_CONTROL, 32'h1);
    expv(16'hFFDC, 2'h0);
    wb(1, ADDR_PULSE_ACCUM_CONTROL, 32'h2);
    expv(16'hFFDA, 2'h0);
    wb(1, ADDR_PULSE_ACCUM_CONTROL, 32'h0);
    expv(16'h0, 2'h0);
    for (int b = 0; b < 4; b++) begin
      wb(1, ADDR_SCICTL, 32'(1 << b));
      serial_flags_i <= 4'(1 << b);
      expv(16'hFFD6, 2'h0);
      serial_flags_i <= ~4'(1 << b);
      expv(16'h0, 2'h0);
    end
  endtask
  task automatic elevation_masks;
    periph_req_i <= 24'h800001;
    expv(16'hFFF2, 2'h0);
    wb(1, ADDR_ELEV, 32'h8A);
    expv(16'hFF8A, 2'h0);
    wb(0, ADDR_CUR, 0);
    check(rd, 32'h0000FF8A);
    wb(1, ADDR_ELEV, 32'hEE);
    expv(16'hFFF2, 2'h0);
    i_mask_i <= 1;
    nonmaskable_ext_request_i <= 1;
    expv(VEC_NONMASKABLE_EXT_REQUEST, 2'h0);
    x_mask_i <= 1;
    expv(16'h0, 2'h0);
  endtask
  // Sticky status, enable and write-one clear
  task automatic status_irq;
    wb(1, ADDR_CLR, 32'h3F);
    wb(0, ADDR_STAT, 0);
    check(rd, 0);
    wb(1, ADDR_IEN, 32'h2);
    ext_reset_req_i <= 1;
    expv(VEC_RESET, RPRIO_TOP);
    ext_reset_req_i <= 0;
    expv(16'h0, 2'h0);
    check(irq_line_o, 1'b1);
    wb(0, ADDR_STAT, 0);
    check(rd, 32'h2);
    wb(1, ADDR_IEN, 32'h1);
    expv(16'h0, 2'h0);
    check(irq_line_o, 1'b0);
    wb(1, ADDR_CLR, 32'h2);
    wb(0, ADDR_STAT, 0);
    check(rd, 0);
    // A write without the low lane enable is ignored
    sel_i <= 4'hE;
    wb(1, ADDR_ELEV, 32'h12);
    sel_i <= 4'hF;
    wb(0, ADDR_ELEV, 0);
    check(rd, 32'hEE);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Main sequence, with a second reset before the final register check
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    regs_after_reset;
    reset_causes;
    timers;
    pulse_and_serial;
    elevation_masks;
    status_irq;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    regs_after_reset;
    finish_test;
  end
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    bad_count++;
    finish_test;
  end
endmodule
